// file: dmrf_ctrl_end.sv
/*
  Controller end: takes register writes from software, issues mode-register-set commands on a
  divided link clock, and paces refresh by temperature.
  Assumes software writes through the plain address/strobe port.
*/
`default_nettype none
`include "dmrf_defs.svh"
module dmrf_ctrl_end
  import dmrf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  dmrf_link_if.ctrl link,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata_r,
  output logic refresh_req_r
);
  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  logic [`DMRF_BA_W-1:0] cmd_ba_r;
  logic [`DMRF_ADDR_W-1:0] cmd_addr_r;
  logic [7:0] temp_r;
  logic go_r;
  logic busy_r;
  logic [`DMRF_ADDR_W-1:0] masked;

  // Reserved bits of the second and third registers are forced low so the device never sees them set.
  always_comb begin
    if (sw_wdata[18:16] == `DMRF_SEL_TWO) begin
      masked = sw_wdata[14:0] & ~`DMRF_TWO_RSVD_MASK;
      // A hot part must never enter self refresh at the normal rate.
      if (temp_r > `DMRF_HOT_LIMIT_C) begin
        masked[`DMRF_TWO_SRT] = 1'b1;
      end
    end else if (sw_wdata[18:16] == `DMRF_SEL_THREE) begin
      masked = sw_wdata[14:0] & ~`DMRF_THREE_RSVD_MASK;
    end else begin
      masked = sw_wdata[14:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_ba_r <= 3'h0;
      cmd_addr_r <= `DMRF_REG_RESET;
      temp_r <= 8'h00;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      // Busy rises one cycle after go, so a pending go also refuses a new command.
      if (sw_wr && sw_addr == 4'h0 && !busy_r && !go_r) begin
        cmd_ba_r <= sw_wdata[18:16];
        cmd_addr_r <= masked;
        go_r <= 1'b1;
      end else if (sw_wr && sw_addr == 4'h4) begin
        temp_r <= sw_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_rdata_r <= 32'h0000_0000;
    end else if (sw_rd && sw_addr == 4'h0) begin
      sw_rdata_r <= {12'h000, busy_r, cmd_ba_r, 1'b0, cmd_addr_r};
    end else if (sw_rd && sw_addr == 4'h4) begin
      sw_rdata_r <= {24'h000000, temp_r};
    end else begin
      sw_rdata_r <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // Link clock and command issue
  // ------------------------------------------------------------------
  logic [1:0] div_r;
  logic ck_fall;
  assign ck_fall = (div_r == 2'h3);

  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= 2'h0;
      link.ck <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r[0]) begin
        link.ck <= ~link.ck;
      end
    end
  end

  dmrf_hstate_t st_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= DMRF_H_IDLE;
      busy_r <= 1'b0;
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.ba <= 3'h0;
      link.addr <= `DMRF_REG_RESET;
    end else begin
      case (st_r)
        DMRF_H_IDLE: begin
          if (go_r) begin
            busy_r <= 1'b1;
            st_r <= DMRF_H_SETUP;
          end
        end
        DMRF_H_SETUP: begin
          // Change pins on the same clk edge that drops the link clock so they are steady at the next rise.
          if (ck_fall) begin
            link.cs_n <= 1'b0;
            link.ras_n <= 1'b0;
            link.cas_n <= 1'b0;
            link.we_n <= 1'b0;
            link.ba <= cmd_ba_r;
            link.addr <= cmd_addr_r;
            st_r <= DMRF_H_HOLD;
          end
        end
        default: begin
          if (ck_fall) begin
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            busy_r <= 1'b0;
            st_r <= DMRF_H_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Refresh pacing
  // ------------------------------------------------------------------
  logic [8:0] refi_r;
  logic hot;
  assign hot = temp_r > `DMRF_HOT_LIMIT_C;

  always_ff @(posedge clk) begin
    if (reset) begin
      refi_r <= 9'h000;
      refresh_req_r <= 1'b0;
    end else begin
      refresh_req_r <= 1'b0;
      if (refi_r >= 9'(hot ? `DMRF_REFI_HOT_CYC : `DMRF_REFI_NORMAL_CYC) - 9'h001) begin
        refi_r <= 9'h000;
        refresh_req_r <= 1'b1;
      end else begin
        refi_r <= refi_r + 9'h001;
      end
    end
  end
endmodule
`default_nettype wire

// file: dmrf_defs.svh
/*
  Constants for the mode-register block: command decode, field positions, reset values and
  timing counts. Assumes it is included by bare name wherever these values are needed.
*/
`ifndef DMRF_DEFS_SVH
`define DMRF_DEFS_SVH
`define DMRF_ADDR_W 15
`define DMRF_BA_W 3
`define DMRF_SEL_ONE 3'h1
`define DMRF_SEL_TWO 3'h2
`define DMRF_SEL_THREE 3'h3
`define DMRF_ONE_QOFF 12
`define DMRF_ONE_WLEV 7
`define DMRF_ONE_AL_HI 4
`define DMRF_ONE_AL_LO 3
`define DMRF_ONE_RTTNOM_A 9
`define DMRF_ONE_RTTNOM_B 6
`define DMRF_ONE_RTTNOM_C 2
`define DMRF_TWO_CWL_HI 5
`define DMRF_TWO_CWL_LO 3
`define DMRF_TWO_SRT 7
`define DMRF_TWO_RTTWR_HI 10
`define DMRF_TWO_RTTWR_LO 9
`define DMRF_TWO_RSVD_MASK 15'h7900
`define DMRF_THREE_MPR_EN 2
`define DMRF_THREE_RSVD_MASK 15'h7ff8
`define DMRF_CWL_BASE 4'h5
`define DMRF_CL_BASE 4'h6
`define DMRF_REG_RESET 15'h0000
`define DMRF_DEFAULT_PATTERN 8'h55
`define DMRF_REFI_NORMAL_NS 7800
`define DMRF_REFI_HOT_NS 3900
`define DMRF_CLK_NS 20
`define DMRF_REFI_NORMAL_CYC (`DMRF_REFI_NORMAL_NS / `DMRF_CLK_NS)
`define DMRF_REFI_HOT_CYC (`DMRF_REFI_HOT_NS / `DMRF_CLK_NS)
`define DMRF_HOT_LIMIT_C 8'h55
`define DMRF_CLK_DIV 4
`endif

// file: dmrf_delay_line.sv
/*
  Variable delay line: a pulse leaves it a programmed number of cycles after it enters.
  Assumes delay stays below DEPTH and is steady while pulses are in flight.
*/
`default_nettype none
module dmrf_delay_line #(
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_pulse,
  input wire logic [4:0] delay,
  output logic out_pulse
);
  logic [DEPTH-1:0] pipe_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= {pipe_r[DEPTH-2:0], in_pulse};
    end
  end

  // A zero delay passes the pulse through in the same cycle.
  always_comb begin
    if (delay == 5'h00) begin
      out_pulse = in_pulse;
    end else begin
      out_pulse = pipe_r[delay - 5'h01];
    end
  end
endmodule
`default_nettype wire

// file: dmrf_link_assertions.sv
/*
  Checker for the controller-to-memory command link.
  Assumes only mode-register-set commands cross this link and clk runs the whole time.
*/
`default_nettype none
`include "dmrf_defs.svh"
module dmrf_link_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DMRF_BA_W-1:0] ba,
  input wire logic [`DMRF_ADDR_W-1:0] addr,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Command shape and timing
  // ----------------------------------------------------------------
  chk_mrs_only_cmd: assert property (!cs_n |-> !ras_n && !cas_n && !we_n)
    else $error("selected command is not a mode register set");
  chk_two_rsvd_zero: assert property (!cs_n && ba == `DMRF_SEL_TWO |->
    (addr & `DMRF_TWO_RSVD_MASK) == 15'h0000)
    else $error("reserved bits set in second register write");
  chk_three_rsvd_zero: assert property (!cs_n && ba == `DMRF_SEL_THREE |->
    (addr & `DMRF_THREE_RSVD_MASK) == 15'h0000)
    else $error("reserved bits set in third register write");
  chk_cmd_length: assert property ($fell(cs_n) |-> !cs_n [*4] ##1 cs_n)
    else $error("command select not held for one link period");
  chk_cmd_sees_ck: assert property ($fell(cs_n) |-> ##[1:4] $rose(ck))
    else $error("no link clock rise inside a command");
  chk_cmd_stable: assert property (!cs_n && !$past(cs_n) |->
    $stable(addr) && $stable(ba) && $stable(we_n))
    else $error("command pins moved while selected");
  chk_ck_half: assert property ($rose(ck) |-> ck ##1 ck ##1 !ck)
    else $error("link clock high time is not two cycles");
  // Only register writes travel here, so the memory must never turn its data pins on.
  chk_mrs_no_drive: assert property (!dq_oe)
    else $error("memory drove data without a read");
  cov_one: cover property ($fell(cs_n) && ba == `DMRF_SEL_ONE);
  cov_two: cover property ($fell(cs_n) && ba == `DMRF_SEL_TWO);
  cov_three: cover property ($fell(cs_n) && ba == `DMRF_SEL_THREE);
endmodule
`default_nettype wire

// file: dmrf_link_if.sv
/*
  Command link between the controller end and the memory end: clock, active-low command
  strobes, bank and address, plus the memory's data-pin enable and pattern data.
  Assumes the bench joins the two modports, or drives the memory-end inputs itself where no controller end is joined.
*/
`default_nettype none
`include "dmrf_defs.svh"
interface dmrf_link_if;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`DMRF_BA_W-1:0] ba;
  logic [`DMRF_ADDR_W-1:0] addr;
  logic [7:0] dq_o;
  logic dq_oe;
  modport ctrl (output ck, cs_n, ras_n, cas_n, we_n, ba, addr, input dq_o, dq_oe);
  modport mem (input ck, cs_n, ras_n, cas_n, we_n, ba, addr, output dq_o, dq_oe);
endinterface
`default_nettype wire

// file: dmrf_mem_end.sv
/*
  Memory end: decodes mode-register-set commands seen on the link clock, keeps the three
  mode registers, times write data and termination, and serves the readout pattern.
  Assumes the link clock is slow against clk so each edge is caught by sampling.
*/
// Overview of operation
// - Output-disable bit set floats all outputs.
// - Controller keeps output-disable zero normally; the controller end passes bit 12 from software unmasked.
// - Bank two selects second mode register.
// - Controller zeroes reserved second-register bits.
// - Address 5:3 picks column write delay.
// - Only whole-cycle latencies exist.
// - Write data delay is posted plus column.
// - Address 10:9 picks write termination value.
// - Write leveling forces baseline termination only.
// - Write termination applies with baseline disabled.
// - Bit seven zero keeps normal refresh rate.
// - Bit seven set doubles self-refresh rate.
// - Controller enables doubling when hot.
// - Controller halves refresh interval when hot.
// - Bank three selects third mode register.
// - Controller zeroes reserved third-register bits.
// - Normal mode ignores pattern selection bits.
// - Pattern mode returns predefined data on reads.
// - Controller performs write leveling; the controller end has none, and the bench drives write_leveling.
// - Commands held posted delay before array.
// - Bank one-only selects first mode register.
`default_nettype none
`include "dmrf_defs.svh"
module dmrf_mem_end
  import dmrf_pkg::*;
#(
  parameter logic [7:0] PATTERN = `DMRF_DEFAULT_PATTERN
) (
  input wire logic clk,
  input wire logic reset,
  dmrf_link_if.mem link,
  input wire logic write_leveling,
  output logic [`DMRF_ADDR_W-1:0] mode_reg_one_r,
  output logic [`DMRF_ADDR_W-1:0] mode_reg_two_r,
  output logic [`DMRF_ADDR_W-1:0] mode_reg_three_r,
  output logic array_cmd_r,
  output logic write_data_due_r,
  output dmrf_term_t termination_r,
  output logic selfrefresh_double_r,
  output logic [4:0] write_data_delay_r
);
  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  localparam int PINS = 5 + `DMRF_BA_W + `DMRF_ADDR_W;
  logic [PINS-1:0] s1_r;
  logic [PINS-1:0] s2_r;
  logic [PINS-1:0] s3_r;
  logic ck_prev_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.addr};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A clock edge counts only once the second and third stages agree.
  logic ck_s;
  assign ck_s = (s2_r[PINS-1] == s3_r[PINS-1]) ? s3_r[PINS-1] : ck_prev_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_s;
    end
  end

  logic ck_rise;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [`DMRF_BA_W-1:0] ba_s;
  logic [`DMRF_ADDR_W-1:0] addr_s;
  assign ck_rise = ck_s && !ck_prev_r;
  assign {cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s} = s3_r[PINS-2:0];

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  logic sel_cmd;
  logic mrs_cmd;
  logic rw_cmd;
  logic wr_cmd;
  logic rd_cmd;
  assign sel_cmd = ck_rise && !cs_n_s;
  assign mrs_cmd = sel_cmd && !ras_n_s && !cas_n_s && !we_n_s;
  assign rw_cmd = sel_cmd && ras_n_s && !cas_n_s;
  assign wr_cmd = rw_cmd && !we_n_s;
  assign rd_cmd = rw_cmd && we_n_s;

  // Each register loads only on its own bank code; every other code leaves all three alone.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg_one_r <= `DMRF_REG_RESET;
      mode_reg_two_r <= `DMRF_REG_RESET;
      mode_reg_three_r <= `DMRF_REG_RESET;
    end else if (mrs_cmd) begin
      if (ba_s == `DMRF_SEL_ONE) begin
        mode_reg_one_r <= addr_s;
      end else if (ba_s == `DMRF_SEL_TWO) begin
        mode_reg_two_r <= addr_s;
      end else if (ba_s == `DMRF_SEL_THREE) begin
        mode_reg_three_r <= addr_s;
      end
    end
  end

  // ------------------------------------------------------------------
  // Latencies
  // ------------------------------------------------------------------
  logic [4:0] column_write_delay;
  logic [4:0] al;
  logic [4:0] cl_base;
  assign column_write_delay = 5'(`DMRF_CWL_BASE) +
               5'(mode_reg_two_r[`DMRF_TWO_CWL_HI:`DMRF_TWO_CWL_LO]);
  assign cl_base = 5'(`DMRF_CL_BASE);
  // Posted delay options are zero, CL-1 and CL-2 in whole cycles.
  always_comb begin
    case (mode_reg_one_r[`DMRF_ONE_AL_HI:`DMRF_ONE_AL_LO])
      2'h1: al = cl_base - 5'h01;
      2'h2: al = cl_base - 5'h02;
      default: al = 5'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      write_data_delay_r <= 5'h00;
    end else begin
      write_data_delay_r <= al + column_write_delay;
    end
  end

  // Delays count clk cycles, one per sampled link edge here would need a link-edge counter;
  // the link is slow so counting clk keeps the pipeline simple and whole-cycle.
  logic array_pulse;
  logic data_pulse;
  dmrf_delay_line #(.DEPTH(32)) u_post (
    .clk(clk),
    .reset(reset),
    .in_pulse(rw_cmd),
    .delay(al),
    .out_pulse(array_pulse)
  );
  dmrf_delay_line #(.DEPTH(32)) u_wdata (
    .clk(clk),
    .reset(reset),
    .in_pulse(wr_cmd),
    .delay(write_data_delay_r),
    .out_pulse(data_pulse)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      array_cmd_r <= 1'b0;
      write_data_due_r <= 1'b0;
    end else begin
      array_cmd_r <= array_pulse;
      write_data_due_r <= data_pulse;
    end
  end

  // ------------------------------------------------------------------
  // Termination and refresh
  // ------------------------------------------------------------------
  logic base_on;
  logic [1:0] wr_term;
  assign base_on = mode_reg_one_r[`DMRF_ONE_RTTNOM_A] | mode_reg_one_r[`DMRF_ONE_RTTNOM_B] |
                   mode_reg_one_r[`DMRF_ONE_RTTNOM_C];
  assign wr_term = mode_reg_two_r[`DMRF_TWO_RTTWR_HI:`DMRF_TWO_RTTWR_LO];

  always_ff @(posedge clk) begin
    if (reset) begin
      termination_r <= DMRF_TERM_OFF;
    end else if (write_leveling || mode_reg_one_r[`DMRF_ONE_WLEV]) begin
      termination_r <= base_on ? DMRF_TERM_BASE : DMRF_TERM_OFF;
    end else if (data_pulse && wr_term != 2'h0) begin
      termination_r <= DMRF_TERM_WRITE;
    end else if (!data_pulse) begin
      termination_r <= base_on ? DMRF_TERM_BASE : DMRF_TERM_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      selfrefresh_double_r <= 1'b0;
    end else begin
      selfrefresh_double_r <= mode_reg_two_r[`DMRF_TWO_SRT];
    end
  end

  // ------------------------------------------------------------------
  // Read data pins
  // ------------------------------------------------------------------
  logic mpr_on;
  assign mpr_on = mode_reg_three_r[`DMRF_THREE_MPR_EN];

  always_ff @(posedge clk) begin
    if (reset) begin
      link.dq_oe <= 1'b0;
      link.dq_o <= 8'h00;
    end else if (mode_reg_one_r[`DMRF_ONE_QOFF]) begin
      link.dq_oe <= 1'b0;
      link.dq_o <= 8'h00;
    end else if (rd_cmd && mpr_on) begin
      link.dq_oe <= 1'b1;
      link.dq_o <= PATTERN;
    end else if (rd_cmd) begin
      link.dq_oe <= 1'b1;
      link.dq_o <= 8'h00;
    end else begin
      link.dq_oe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: dmrf_pkg.sv
/*
  Types shared by both ends of the mode-register link.
  Assumes dmrf_defs.svh sits beside it.
*/
`default_nettype none
`include "dmrf_defs.svh"
package dmrf_pkg;
  typedef enum logic [1:0] {DMRF_TERM_OFF, DMRF_TERM_BASE, DMRF_TERM_WRITE} dmrf_term_t;
  typedef enum logic [1:0] {DMRF_H_IDLE, DMRF_H_SETUP, DMRF_H_HOLD} dmrf_hstate_t;
endpackage
`default_nettype wire

// file: tb_dram_mode_register_fields.sv
/*
  Self-checking bench: the controller end faces one memory end on a shared link, and a
  second memory end is driven straight from the bench for reads and writes.
  Assumes the design files and dmrf_defs.svh are compiled first.
*/
`default_nettype none
`include "dmrf_defs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_dram_mode_register_fields;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic wlev = 1'b0;
  logic [31:0] sw_rdata_r;
  logic refresh_req_r;
  logic [14:0] m1_one, m1_two, m1_three, m2_one, m2_two, m2_three;
  logic m1_arr, m1_due, m1_srd, m2_arr, m2_due, m2_srd;
  logic [4:0] m1_wdd, m2_wdd;
  dmrf_pkg::dmrf_term_t m1_term, m2_term;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_arr = 0;
  int t_due = 0;
  int n_oe = 0;
  logic [7:0] oe_dat = 8'h00;
  int n_wt = 0;
  dmrf_link_if link1 ();
  dmrf_link_if link2 ();
  dmrf_ctrl_end dmrf_ctrl_end_inst (.clk(clk), .reset(reset), .link(link1.ctrl),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_r(sw_rdata_r), .refresh_req_r(refresh_req_r));
  dmrf_mem_end dmrf_mem_end_inst (.clk(clk), .reset(reset), .link(link1.mem),
    .write_leveling(wlev), .mode_reg_one_r(m1_one), .mode_reg_two_r(m1_two),
    .mode_reg_three_r(m1_three), .array_cmd_r(m1_arr), .write_data_due_r(m1_due),
    .termination_r(m1_term), .selfrefresh_double_r(m1_srd), .write_data_delay_r(m1_wdd));
  dmrf_mem_end dmrf_mem_end_b_inst (.clk(clk), .reset(reset), .link(link2.mem),
    .write_leveling(wlev), .mode_reg_one_r(m2_one), .mode_reg_two_r(m2_two),
    .mode_reg_three_r(m2_three), .array_cmd_r(m2_arr), .write_data_due_r(m2_due),
    .termination_r(m2_term), .selfrefresh_double_r(m2_srd), .write_data_delay_r(m2_wdd));
  dmrf_link_assertions dmrf_link_assertions_inst (.clk(clk), .reset(reset), .ck(link1.ck),
    .cs_n(link1.cs_n), .ras_n(link1.ras_n), .cas_n(link1.cas_n), .we_n(link1.we_n),
    .ba(link1.ba), .addr(link1.addr), .dq_o(link1.dq_o), .dq_oe(link1.dq_oe));
  initial begin
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Watchers and transfer tasks
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (m2_arr === 1'b1) t_arr <= cyc;
    if (m2_due === 1'b1) t_due <= cyc;
    if (link2.dq_oe === 1'b1) begin
      n_oe <= n_oe + 1;
      oe_dat <= link2.dq_o;
    end
    if (m2_term === dmrf_pkg::DMRF_TERM_WRITE) n_wt <= n_wt + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata_r;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [14:0] a);
    logic [31:0] d;
    int n;
    n = 0;
    sw_write(4'h0, {13'h0000, b, 1'b0, a});
    repeat (2) @(posedge clk);
    do begin
      sw_read(4'h0, d);
      n++;
    end while (d[19] !== 1'b0 && n < 40);
    `CHK("busy", 1'b0, d[19])
    repeat (12) @(posedge clk);
  endtask
  // Bench-made link clock: one 80 ns high pulse per command, low between commands; released strobes go high, bank and address invert.
  task automatic lk(input logic [3:0] s, input logic [2:0] b, input logic [14:0] a);
    @(posedge clk);
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} <= s;
    link2.ba <= b;
    link2.addr <= a;
    repeat (4) @(posedge clk);
    link2.ck <= 1'b1;
    repeat (4) @(posedge clk);
    link2.ck <= 1'b0;
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} <= 4'hf;
    link2.ba <= ~b;
    link2.addr <= ~a;
    repeat (16) @(posedge clk);
  endtask
  task automatic interval(output int n);
    n = 0;
    repeat (3) begin
      n = 1;
      @(posedge clk);
      while (refresh_req_r !== 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    mrs(3'h2, 15'h7fff);
    `CHK("two masked", 15'h06ff, m1_two)
    `CHK("one untouched", 15'h0000, m1_one)
    `CHK("srt on", 1'b1, m1_srd)
    `CHK("wdd cwl7", 5'd12, m1_wdd)
    mrs(3'h2, 15'h0010);
    `CHK("srt off", 1'b0, m1_srd)
    `CHK("wdd cwl2", 5'd7, m1_wdd)
    mrs(3'h1, 15'h0008);
    `CHK("one", 15'h0008, m1_one)
    `CHK("wdd al1", 5'd12, m1_wdd)
    `CHK("two kept", 15'h0010, m1_two)
    mrs(3'h1, 15'h0010);
    `CHK("wdd al2", 5'd11, m1_wdd)
    mrs(3'h4, 15'h1234);
    `CHK("bank4 one", 15'h0010, m1_one)
    `CHK("bank4 two", 15'h0010, m1_two)
    mrs(3'h3, 15'h7fff);
    `CHK("three masked", 15'h0007, m1_three)
    `CHK("three one", 15'h0010, m1_one)
    $display("done t_regs");
  endtask
  task automatic t_refresh;
    logic [31:0] d;
    int n;
    sw_read(4'hc, d);
    `CHK("unmapped", 32'h0000_0000, d)
    sw_write(4'h4, 32'h0000_0056);
    mrs(3'h2, 15'h0010);
    `CHK("hot srt", 1'b1, m1_srd)
    interval(n);
    `CHK("hot interval", 195, n)
    sw_write(4'h4, 32'h0000_0055);
    interval(n);
    `CHK("normal interval", 390, n)
    $display("done t_refresh");
  endtask
  task automatic t_reads;
    int n0;
    n0 = n_oe;
    lk(4'h0, 3'h3, 15'h0003);
    `CHK("b three", 15'h0003, m2_three)
    lk(4'h5, 3'h0, 15'h0000);
    `CHK("read count", n0 + 1, n_oe)
    `CHK("read normal", 8'h00, oe_dat)
    lk(4'h0, 3'h3, 15'h0004);
    lk(4'h5, 3'h0, 15'h0000);
    `CHK("pattern count", n0 + 2, n_oe)
    `CHK("pattern", `DMRF_DEFAULT_PATTERN, oe_dat)
    lk(4'h0, 3'h1, 15'h1000);
    lk(4'h5, 3'h0, 15'h0000);
    `CHK("outputs off", n0 + 2, n_oe)
    $display("done t_reads");
  endtask
  task automatic t_write;
    int c0;
    int d1;
    int w0;
    lk(4'h0, 3'h1, 15'h0008);
    lk(4'h0, 3'h2, 15'h0210);
    `CHK("b wdd", 5'd12, m2_wdd)
    w0 = n_wt;
    c0 = cyc;
    lk(4'h4, 3'h0, 15'h0000);
    repeat (10) @(posedge clk);
    d1 = t_arr - c0;
    `CHK("data after array", 7, t_due - t_arr)
    `CHK("write term", 1'b1, n_wt > w0)
    // Same write with no posted delay: the array command moves earlier by exactly that delay.
    lk(4'h0, 3'h1, 15'h0000);
    wlev <= 1'b1;
    w0 = n_wt;
    c0 = cyc;
    lk(4'h4, 3'h0, 15'h0000);
    repeat (10) @(posedge clk);
    `CHK("posted delay", `DMRF_CL_BASE - 1, d1 - (t_arr - c0))
    `CHK("leveling term", 1'b0, n_wt > w0)
    wlev <= 1'b0;
    $display("done t_write");
  endtask
  initial begin
    link2.ck = 1'b0;
    {link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = 4'hf;
    link2.ba = 3'h0;
    link2.addr = 15'h0000;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset regs", 15'h0000, m1_one | m1_two | m1_three)
    `CHK("reset select", 1'b1, link1.cs_n)
    t_regs();
    t_refresh();
    t_reads();
    t_write();
    test_done();
  end
endmodule
`default_nettype wire
